// >>> rtl/cpusr_consts.vh
// cpusr_consts.vh: offsets, field positions, reset values for the status block
// assumes inclusion by bare name from rtl/ design files
`ifndef CPUSR_CONSTS_VH
`define CPUSR_CONSTS_VH

// register word addresses (4-bit port address)
`define CPUSR_ADDR_FLAGS    4'h0
`define CPUSR_ADDR_IRQ_STAT 4'h1
`define CPUSR_ADDR_IRQ_MASK 4'h2
`define CPUSR_ADDR_CTRL     4'h3

// status register bit positions
`define CPUSR_BIT_ACC_A_OVF   15
`define CPUSR_BIT_ACC_B_OVF   14
`define CPUSR_BIT_CLIP_A      13
`define CPUSR_BIT_CLIP_B      12
`define CPUSR_BIT_EITHER_OVF  11
`define CPUSR_BIT_EITHER_CLIP 10
`define CPUSR_BIT_LOOP        9
`define CPUSR_BIT_HALF_CARRY  8
`define CPUSR_BIT_PRIO_HI     7
`define CPUSR_BIT_PRIO_LO     5
`define CPUSR_BIT_RA   4
`define CPUSR_BIT_N    3
`define CPUSR_BIT_OV   2
`define CPUSR_BIT_Z    1
`define CPUSR_BIT_C    0

// interrupt status bits
`define CPUSR_EV_SAT_A 0
`define CPUSR_EV_SAT_B 1
`define CPUSR_EV_OVF   2
`define CPUSR_EV_W     3

// control register bit
`define CPUSR_CTRL_NEST_DIS 0

`define CPUSR_RESET_FLAGS 16'h0000
`define CPUSR_RESET_EV    4'h0

`endif

// >>> rtl/cpusr_sticky.v
// cpusr_sticky.v: one sticky flag, hardware set wins over software clear
// assumes set and clear come from logic on clk
`timescale 1ns/10ps
`default_nettype none
module cpusr_sticky
(
    // clock and reset
    input  wire clk,
    input  wire sys_rst,
    // control
    input  wire set_pulse,
    input  wire clr_pulse,
    input  wire wr_en,
    input  wire wr_val,
    // state
    output reg  flag_reg
);

    always @(posedge clk)
    begin
        if (sys_rst)
            flag_reg <= 1'b0;
        else if (set_pulse)
            flag_reg <= 1'b1;
        else if (clr_pulse)
            flag_reg <= 1'b0;
        else if (wr_en)
            flag_reg <= wr_val;
    end

endmodule
`default_nettype wire

// >>> rtl/cpusr_top.v
// cpusr_top.v: cpu status flags register with sticky clip bits and irq
// assumes core-side flag strobes come from logic on clk (no synchroniser)
`timescale 1ns/10ps
`default_nettype none
`include "cpusr_consts.vh"
module cpusr_top
#(
    parameter HAS_DSP = 1
)
(
    // clock and reset
    input  wire        clk,
    input  wire        sys_rst,
    // register port
    input  wire [3:0]  reg_addr,
    input  wire [15:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [15:0] reg_rdata,
    // core flag updates
    input  wire        acc_a_ovf_in,
    input  wire        acc_b_ovf_in,
    input  wire        acc_a_sat_set,
    input  wire        acc_b_sat_set,
    input  wire        loop_active_in,
    input  wire        alu_flags_we,
    input  wire [4:0]  alu_flags_in,
    input  wire        half_carry_in,
    // status outputs
    output wire [15:0] cpu_status_flags,
    output wire [2:0]  cpu_priority_level_low,
    output wire        nesting_disable,
    output wire        irq
);

    // without the accumulator engine every engine bit stays zero
    localparam [0:0] DSP = (HAS_DSP != 0) ? 1'b1 : 1'b0;

    reg        acc_a_ovf_flag_reg;
    reg        acc_b_ovf_flag_reg;
    reg        loop_active_flag_reg;
    reg        half_carry_flag_reg;
    reg [2:0]  prio_reg;
    reg [4:0]  alu_reg;
    reg        nest_dis_reg;
    reg [3:0]  ev_stat_reg;
    reg [3:0]  ev_mask_reg;
    reg [15:0] rdata_next;
    wire       acc_a_clip_sticky;
    wire       acc_b_clip_sticky;
    wire       either_acc_ovf_flag;
    wire       either_acc_clip_sticky;
    wire       wr_flags;
    wire       wr_ctrl;
    wire       wr_stat;
    wire       wr_mask;
    wire       clip_wr;
    wire       clip_clear;
    wire [3:0] ev_in;

    // one strobe-and-address decode shared by every register
    function addr_hit;
        input       strobe;
        input [3:0] addr;
        input [3:0] target;
        begin
            addr_hit = strobe && (addr == target);
        end
    endfunction

    assign wr_flags = addr_hit(reg_wr, reg_addr, `CPUSR_ADDR_FLAGS);
    assign wr_ctrl  = addr_hit(reg_wr, reg_addr, `CPUSR_ADDR_CTRL);
    assign wr_stat  = addr_hit(reg_wr, reg_addr, `CPUSR_ADDR_IRQ_STAT);
    assign wr_mask  = addr_hit(reg_wr, reg_addr, `CPUSR_ADDR_IRQ_MASK);
    // software reaches the clip bits only where the engine exists
    assign clip_wr    = wr_flags && DSP;
    // a zero written to the combined bit clears both clip bits
    assign clip_clear = clip_wr && !reg_wdata[`CPUSR_BIT_EITHER_CLIP];

    // set wins over a same-cycle clear or write, so software cannot
    // race a fresh saturation away
    cpusr_sticky u_clip_a
    (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .set_pulse (acc_a_sat_set && DSP),
        .clr_pulse (clip_clear),
        .wr_en     (clip_wr),
        .wr_val    (reg_wdata[`CPUSR_BIT_CLIP_A]),
        .flag_reg  (acc_a_clip_sticky)
    );

    cpusr_sticky u_clip_b
    (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .set_pulse (acc_b_sat_set && DSP),
        .clr_pulse (clip_clear),
        .wr_en     (clip_wr),
        .wr_val    (reg_wdata[`CPUSR_BIT_CLIP_B]),
        .flag_reg  (acc_b_clip_sticky)
    );

    assign either_acc_ovf_flag    = acc_a_ovf_flag_reg | acc_b_ovf_flag_reg;
    assign either_acc_clip_sticky = acc_a_clip_sticky | acc_b_clip_sticky;

    // overflow and loop bits follow the engine; core owns them each cycle
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            acc_a_ovf_flag_reg   <= 1'b0;
            acc_b_ovf_flag_reg   <= 1'b0;
            loop_active_flag_reg <= 1'b0;
        end
        else
        begin
            acc_a_ovf_flag_reg   <= acc_a_ovf_in && DSP;
            acc_b_ovf_flag_reg   <= acc_b_ovf_in && DSP;
            loop_active_flag_reg <= loop_active_in && DSP;
        end
    end

    // software-writable low flags; core update wins over a same-cycle write
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            half_carry_flag_reg <= 1'b0;
            alu_reg             <= 5'h00;
            prio_reg            <= 3'h0;
        end
        else
        begin
            if (alu_flags_we)
            begin
                half_carry_flag_reg <= half_carry_in;
                alu_reg             <= alu_flags_in;
            end
            else if (wr_flags)
            begin
                half_carry_flag_reg <= reg_wdata[`CPUSR_BIT_HALF_CARRY];
                // ra is the core's alone; a status write leaves it as is
                alu_reg <= {alu_reg[4], reg_wdata[`CPUSR_BIT_N:`CPUSR_BIT_C]};
            end
            if (wr_flags && !nest_dis_reg)
                prio_reg <= reg_wdata[`CPUSR_BIT_PRIO_HI:`CPUSR_BIT_PRIO_LO];
        end
    end

    // ra bit is read-only from the register port side; kept in alu_reg[4]
    assign cpu_status_flags = {acc_a_ovf_flag_reg, acc_b_ovf_flag_reg,
                               acc_a_clip_sticky, acc_b_clip_sticky,
                               either_acc_ovf_flag, either_acc_clip_sticky,
                               loop_active_flag_reg, half_carry_flag_reg,
                               prio_reg, alu_reg};
    assign cpu_priority_level_low = prio_reg;
    assign nesting_disable        = nest_dis_reg;

    // events: new saturation on either accumulator, any overflow, sw write
    // overflow is a level, so its event re-fires while it stands
    assign ev_in = {wr_flags,
                    either_acc_ovf_flag,
                    acc_b_sat_set && DSP,
                    acc_a_sat_set && DSP};

    // control, interrupt status (write one to clear, set wins) and mask
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            nest_dis_reg <= 1'b0;
            ev_stat_reg  <= `CPUSR_RESET_EV;
            ev_mask_reg  <= `CPUSR_RESET_EV;
        end
        else
        begin
            if (wr_ctrl)
                nest_dis_reg <= reg_wdata[`CPUSR_CTRL_NEST_DIS];
            if (wr_mask)
                ev_mask_reg <= reg_wdata[3:0];
            if (wr_stat)
                ev_stat_reg <= (ev_stat_reg & ~reg_wdata[3:0]) | ev_in;
            else
                ev_stat_reg <= ev_stat_reg | ev_in;
        end
    end

    assign irq = |(ev_stat_reg & ev_mask_reg);

    // read mux; unmapped addresses read as zero
    always @*
    begin
        case (reg_addr)
            `CPUSR_ADDR_FLAGS:    rdata_next = cpu_status_flags;
            `CPUSR_ADDR_IRQ_STAT: rdata_next = {12'h000, ev_stat_reg};
            `CPUSR_ADDR_IRQ_MASK: rdata_next = {12'h000, ev_mask_reg};
            `CPUSR_ADDR_CTRL:     rdata_next = {15'h0000, nest_dis_reg};
            default:              rdata_next = 16'h0000;
        endcase
    end

    // read data valid the cycle after the strobe; zero otherwise
    always @(posedge clk)
    begin
        if (sys_rst)
            reg_rdata <= 16'h0000;
        else if (reg_rd)
            reg_rdata <= rdata_next;
        else
            reg_rdata <= 16'h0000;
    end

endmodule
`default_nettype wire

// >>> tb/cpusr_properties.sv
// cpusr_properties.sv: checker for the cpu status flags block
// assumes bind onto cpusr_top, one clock, sync reset
`timescale 1ns/10ps
`default_nettype none
module cpusr_properties
#(
    parameter HAS_DSP = 1
)
(
    // clock and reset
    input wire logic        clk,
    input wire logic        sys_rst,
    // register port
    input wire logic [3:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    // core events
    input wire logic        acc_a_sat_set,
    input wire logic        acc_b_sat_set,
    // status
    input wire logic [15:0] cpu_status_flags,
    input wire logic [2:0]  cpu_priority_level_low,
    input wire logic        nesting_disable
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire logic fw = reg_wr && reg_addr == 4'h0 && HAS_DSP != 0;
    // a hardware set in the same cycle wins, so leave it out
    wire logic q = fw && !acc_a_sat_set && !acc_b_sat_set;
    clip_write_a: assert property (
        q && reg_wdata[10] |=>
        cpu_status_flags[13:12] == $past(reg_wdata[13:12]))
        else $error("clip bits not written");
    clip_clear_a: assert property (
        q && !reg_wdata[10] |=> cpu_status_flags[13:12] == 2'h0)
        else $error("clip bits not cleared");
    ipl_lock_a: assert property (
        reg_wr && reg_addr == 4'h0 && nesting_disable
        |=> $stable(cpu_priority_level_low))
        else $error("priority changed while locked");
    sat_hold_a: assert property (
        HAS_DSP != 0 && acc_a_sat_set || cpu_status_flags[13] && !fw
        |=> cpu_status_flags[13])
        else $error("clip bit a lost");
    or_flags_a: assert property (
        cpu_status_flags[11] == |cpu_status_flags[15:14]
        && cpu_status_flags[10] == |cpu_status_flags[13:12])
        else $error("combined flags wrong");
    no_dsp_a: assert property (
        HAS_DSP == 0 |-> cpu_status_flags[15:9] == 7'h00)
        else $error("accumulator bits without engine");
endmodule
bind cpusr_top cpusr_properties #(.HAS_DSP(HAS_DSP)) u_props (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .acc_a_sat_set(acc_a_sat_set), .acc_b_sat_set(acc_b_sat_set),
    .cpu_status_flags(cpu_status_flags),
    .cpu_priority_level_low(cpu_priority_level_low),
    .nesting_disable(nesting_disable));
`default_nettype wire

// >>> tb/tb.sv
// tb.sv: self-checking bench for the cpu status flags block
// assumes rtl files and the checker compiled before it
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [3:0]  a = 4'h0;
    logic [15:0] d = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        sat_a = 1'b0;
    logic        sat_b = 1'b0;
    logic        ovf_b = 1'b0;
    logic        alu_we = 1'b0;
    logic [4:0]  alu_in = 5'h00;
    logic        hc = 1'b0;
    wire logic [15:0] rdata;
    wire logic [15:0] flags;
    wire logic [15:0] nd_flags;
    wire logic [2:0]  prio;
    wire logic        nst;
    wire logic        irq;
    int          n_mismatch = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    always #4 clk = ~clk;
    // overflow a and loop inputs are tied off
    cpusr_top dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(a),
        .reg_wdata(d), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
        .acc_a_ovf_in(1'b0), .acc_b_ovf_in(ovf_b), .acc_a_sat_set(sat_a),
        .acc_b_sat_set(sat_b), .loop_active_in(1'b0),
        .alu_flags_we(alu_we), .alu_flags_in(alu_in), .half_carry_in(hc),
        .cpu_status_flags(flags), .cpu_priority_level_low(prio),
        .nesting_disable(nst), .irq(irq));
    // same stimulus into a core without the accumulator engine
    cpusr_top #(.HAS_DSP(0)) dut_nodsp (.clk(clk), .sys_rst(sys_rst),
        .reg_addr(a), .reg_wdata(d), .reg_wr(wr), .reg_rd(rd),
        .reg_rdata(), .acc_a_ovf_in(1'b0), .acc_b_ovf_in(ovf_b),
        .acc_a_sat_set(sat_a), .acc_b_sat_set(sat_b),
        .loop_active_in(1'b0), .alu_flags_we(alu_we),
        .alu_flags_in(alu_in), .half_carry_in(hc),
        .cpu_status_flags(nd_flags), .cpu_priority_level_low(),
        .nesting_disable(), .irq());
    task automatic chk16(input logic [15:0] g, input logic [15:0] e);
        cmp_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        chk16({15'h0000, g}, {15'h0000, e});
    endtask
    task automatic wreg(input logic [3:0] ad, input logic [15:0] dd);
        @(posedge clk);
        a <= ad;
        d <= dd;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rreg(input logic [3:0] ad, input logic [15:0] e);
        @(posedge clk);
        a <= ad;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk16(rdata, e);
    endtask
    task automatic stop_test;
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 2000)
        begin
            n_mismatch++;
            stop_test();
        end
    end
    initial
    begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        rreg(4'h0, 16'h0000);
        chk1(irq, 1'b0);
        @(posedge clk);
        sat_a <= 1'b1;
        sat_b <= 1'b1;
        @(posedge clk);
        sat_a <= 1'b0;
        sat_b <= 1'b0;
        rreg(4'h0, 16'h3400);
        chk16({9'h000, nd_flags[15:9]}, 16'h0000);
        wreg(4'h0, 16'h1400);
        rreg(4'h0, 16'h1400);
        chk16({9'h000, nd_flags[15:9]}, 16'h0000);
        wreg(4'h0, 16'h3000);
        rreg(4'h0, 16'h0000);
        wreg(4'h3, 16'h0001);
        chk1(nst, 1'b1);
        wreg(4'h0, 16'h00e0);
        rreg(4'h0, 16'h0000);
        chk16({13'h0000, prio}, 16'h0000);
        wreg(4'h3, 16'h0000);
        wreg(4'h0, 16'h00e0);
        rreg(4'h0, 16'h00e0);
        chk16({13'h0000, prio}, 16'h0007);
        @(posedge clk);
        alu_we <= 1'b1;
        alu_in <= 5'h11;
        hc <= 1'b1;
        @(posedge clk);
        alu_we <= 1'b0;
        rreg(4'h0, 16'h01f1);
        wreg(4'h0, 16'h00e0);
        rreg(4'h0, 16'h00f0);
        @(posedge clk);
        ovf_b <= 1'b1;
        rreg(4'h0, 16'h48f0);
        chk16(flags, 16'h48f0);
        rreg(4'h1, 16'h000f);
        chk1(irq, 1'b0);
        wreg(4'h2, 16'h0001);
        chk1(irq, 1'b1);
        wreg(4'h1, 16'h0001);
        chk1(irq, 1'b0);
        rreg(4'h1, 16'h000e);
        rreg(4'h7, 16'h0000);
        stop_test();
    end
endmodule
`default_nettype wire
